// *** link_bringup_pkg.sv ***
package link_bringup_pkg;

    // ==========================================================
    // Register addresses (12-bit space of the control port)
    localparam logic [11:0] ADDR_SERIAL_INTERFACE_CONFIG = 12'h000;
    localparam logic [11:0] ADDR_CHIP_KIND_CODE = 12'h003;
    localparam logic [11:0] ADDR_PRODUCT_CODE_LOW = 12'h004;
    localparam logic [11:0] ADDR_PRODUCT_CODE_HIGH = 12'h005;
    localparam logic [11:0] ADDR_GRADE_AND_REVISION = 12'h006;
    localparam logic [11:0] ADDR_CONVERTER_PAGE_SELECT = 12'h008;
    localparam logic [11:0] ADDR_SCRATCH_REGISTER = 12'h00A;
    localparam logic [11:0] ADDR_POWER_DOWN_CONTROL = 12'h011;
    localparam logic [11:0] ADDR_TRANSMIT_ENABLE_MASK = 12'h012;
    localparam logic [11:0] ADDR_OUTPUT_PROTECT_CONTROL = 12'h013;
    localparam logic [11:0] ADDR_GROUP_DELAY_SETTING = 12'h014;
    localparam logic [11:0] ADDR_IRQ_ENABLE_PLL_CAL = 12'h01F;
    localparam logic [11:0] ADDR_IRQ_ENABLE_PRBS = 12'h020;
    localparam logic [11:0] ADDR_IRQ_ENABLE_PATH0_SYNC = 12'h021;
    localparam logic [11:0] ADDR_SYNC_CONTROL = 12'h03A;
    localparam logic [11:0] ADDR_SYNC_STATUS = 12'h03B;
    localparam logic [11:0] ADDR_LINK_CONTROL = 12'h300;
    localparam logic [11:0] ADDR_SUBCLASS_SELECT = 12'h301;
    localparam logic [11:0] ADDR_MF_DELAY_0 = 12'h304;
    localparam logic [11:0] ADDR_MF_DELAY_1 = 12'h305;
    localparam logic [11:0] ADDR_MF_BUF_DELAY_0 = 12'h306;
    localparam logic [11:0] ADDR_MF_BUF_DELAY_1 = 12'h307;
    localparam logic [11:0] ADDR_CODE_GROUP_SYNC = 12'h470;
    localparam logic [11:0] ADDR_FRAME_SYNC = 12'h471;
    localparam logic [11:0] ADDR_CHECKSUM_GOOD = 12'h472;
    localparam logic [11:0] ADDR_LANE_ALIGN = 12'h473;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_SERIAL_INTERFACE_CONFIG = 8'h00;
    localparam logic [7:0] RST_CONVERTER_PAGE_SELECT = 8'h03;
    localparam logic [7:0] RST_SCRATCH_REGISTER = 8'h00;
    localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h7C;
    localparam logic [7:0] RST_TRANSMIT_ENABLE_MASK = 8'h00;
    localparam logic [7:0] RST_OUTPUT_PROTECT_CONTROL = 8'h20;
    localparam logic [7:0] RST_GROUP_DELAY_SETTING = 8'h88;
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_SYNC_CONTROL = 8'h00;
    localparam logic [7:0] RST_LINK_CONTROL = 8'h00;
    localparam logic [7:0] RST_GENERIC = 8'h00;

    // Arbitrary neutral identity values
    localparam logic [7:0] ID_CHIP_KIND = 8'h5A;
    localparam logic [7:0] ID_PRODUCT_LOW = 8'h12;
    localparam logic [7:0] ID_PRODUCT_HIGH = 8'h34;
    localparam logic [7:0] ID_GRADE_REV = 8'h11;

    // ==========================================================
    // Field positions
    localparam int SYNC_ENABLE_BIT = 7;
    localparam int SYNC_ARM_BIT = 6;
    localparam int SYNC_CLR_STICKY_BIT = 5;
    localparam int SYNC_CLR_LAST_BIT = 4;
    localparam int SYNC_MODE_MSB = 3;
    localparam logic [3:0] SYNC_MODE_ONE_SHOT = 4'h1;
    localparam int SYNC_BUSY_BIT = 7;
    localparam int SYNC_LOCK_BIT = 3;
    localparam int LINK0_ENABLE_BIT = 0;
    localparam int LINK_PAGE_BIT = 2;
    localparam int INTFCONF_SELF_CLEAR_MASK_BIT = 0;

    // ==========================================================
    // Lane checks
    localparam int K28_5_RUN = 4;
    localparam logic [9:0] K28_5_RD_NEG = 10'b00_1111_1010;
    localparam logic [9:0] K28_5_RD_POS = 10'b11_0000_0101;

    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_ARMED,
        SYNC_DONE
    } sync_state_t;

endpackage

// *** lane_monitor.sv ***
// ==========================================================
// Per-lane alignment tracker fed with 10-bit code groups
module lane_monitor (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Lane side
    input wire logic i_enable,
    input wire logic i_group_valid,
    input wire logic [9:0] i_group,
    input wire logic i_frame_aligned,
    input wire logic i_checksum_ok,
    input wire logic i_ilas_done,
    // Status
    output logic o_code_group_sync,
    output logic o_frame_sync,
    output logic o_checksum_good,
    output logic o_lane_aligned
);

    logic [2:0] k_run;
    logic is_k;

    // Comma detect in either disparity
    assign is_k = (i_group == link_bringup_pkg::K28_5_RD_NEG) ||
                  (i_group == link_bringup_pkg::K28_5_RD_POS);

    // Consecutive comma counter and sync flag
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !i_enable) begin
            k_run <= 3'd0;
            o_code_group_sync <= 1'b0;
        end else if (i_group_valid && !o_code_group_sync) begin
            if (is_k) begin
                k_run <= k_run + 3'd1;
                if (k_run == 3'(link_bringup_pkg::K28_5_RUN - 1)) begin
                    o_code_group_sync <= 1'b1;
                end
            end else begin
                k_run <= 3'd0;
            end
        end
    end

    // Later stages only count once code groups are locked
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !i_enable || !o_code_group_sync) begin
            o_frame_sync <= 1'b0;
            o_checksum_good <= 1'b0;
            o_lane_aligned <= 1'b0;
        end else begin
            o_frame_sync <= o_frame_sync | i_frame_aligned;
            o_checksum_good <= o_checksum_good | i_checksum_ok;
            o_lane_aligned <= o_lane_aligned | i_ilas_done;
        end
    end

endmodule

// *** link_bringup_config_regs.sv ***
module link_bringup_config_regs #(
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Register access port
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Alignment reference input
    input wire logic i_sysref,
    // Serial lane inputs (deserialised code groups)
    input wire logic [LANES-1:0] i_serial_lane_valid,
    input wire logic [LANES*10-1:0] i_serial_lane_inputs,
    input wire logic [LANES-1:0] i_lane_frame_aligned,
    input wire logic [LANES-1:0] i_lane_checksum_ok,
    input wire logic [LANES-1:0] i_lane_ilas_done,
    // Link outputs
    output logic o_link0_sync_request_out,
    output logic o_link0_enable,
    output logic o_sync_done,
    output logic [7:0] o_power_down_control,
    output logic [7:0] o_transmit_enable_mask
);

    // ==========================================================
    // Storage
    logic [7:0] serial_interface_config;
    logic [7:0] converter_page_select;
    logic [7:0] scratch_register;
    logic [7:0] power_down_control;
    logic [7:0] transmit_enable_mask;
    logic [7:0] output_protect_control;
    logic [7:0] group_delay_setting;
    logic [7:0] irq_enable_pll_cal;
    logic [7:0] irq_enable_prbs;
    logic [7:0] irq_enable_path0_sync;
    logic [7:0] sync_control;
    logic [7:0] link_control;
    logic [7:0] subclass_select;
    logic [7:0] mf_delay [2];
    logic [7:0] mf_buf_delay [2];
    logic [2:0] sysref_sync;
    logic sysref_edge;
    logic sync_rotate;
    logic sync_sticky;
    link_bringup_pkg::sync_state_t sync_state;
    logic [LANES-1:0] cgs_lane;
    logic [LANES-1:0] fs_lane;
    logic [LANES-1:0] cks_lane;
    logic [LANES-1:0] ila_lane;
    logic [LANES-1:0] lane_valid_q1;
    logic [LANES-1:0] lane_valid_q2;
    logic [LANES*10-1:0] lane_data_q1;
    logic [LANES*10-1:0] lane_data_q2;
    logic [LANES-1:0] fa_q1;
    logic [LANES-1:0] fa_q2;
    logic [LANES-1:0] ck_q1;
    logic [LANES-1:0] ck_q2;
    logic [LANES-1:0] il_q1;
    logic [LANES-1:0] il_q2;

    // Status byte: all ones when every lane set
    function automatic logic [7:0] all_lanes(input logic [LANES-1:0] flags);
        return (&flags) ? 8'hFF : 8'h00;
    endfunction

    // ==========================================================
    // Register writes
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            serial_interface_config <= link_bringup_pkg::RST_SERIAL_INTERFACE_CONFIG;
            converter_page_select <= link_bringup_pkg::RST_CONVERTER_PAGE_SELECT;
            scratch_register <= link_bringup_pkg::RST_SCRATCH_REGISTER;
            power_down_control <= link_bringup_pkg::RST_POWER_DOWN_CONTROL;
            transmit_enable_mask <= link_bringup_pkg::RST_TRANSMIT_ENABLE_MASK;
            output_protect_control <= link_bringup_pkg::RST_OUTPUT_PROTECT_CONTROL;
            group_delay_setting <= link_bringup_pkg::RST_GROUP_DELAY_SETTING;
            irq_enable_pll_cal <= link_bringup_pkg::RST_IRQ_ENABLE;
            irq_enable_prbs <= link_bringup_pkg::RST_IRQ_ENABLE;
            irq_enable_path0_sync <= link_bringup_pkg::RST_IRQ_ENABLE;
            link_control <= link_bringup_pkg::RST_LINK_CONTROL;
            subclass_select <= link_bringup_pkg::RST_GENERIC;
            mf_delay[0] <= link_bringup_pkg::RST_GENERIC;
            mf_delay[1] <= link_bringup_pkg::RST_GENERIC;
            mf_buf_delay[0] <= link_bringup_pkg::RST_GENERIC;
            mf_buf_delay[1] <= link_bringup_pkg::RST_GENERIC;
        end else if (i_reg_write) begin
            unique case (i_reg_addr)
                link_bringup_pkg::ADDR_SERIAL_INTERFACE_CONFIG: begin
                    serial_interface_config <= i_reg_wdata;
                end
                link_bringup_pkg::ADDR_CONVERTER_PAGE_SELECT: begin
                    converter_page_select <= i_reg_wdata;
                end
                link_bringup_pkg::ADDR_SCRATCH_REGISTER: scratch_register <= i_reg_wdata;
                link_bringup_pkg::ADDR_POWER_DOWN_CONTROL: power_down_control <= i_reg_wdata;
                link_bringup_pkg::ADDR_TRANSMIT_ENABLE_MASK: begin
                    transmit_enable_mask <= i_reg_wdata;
                end
                link_bringup_pkg::ADDR_OUTPUT_PROTECT_CONTROL: begin
                    output_protect_control <= i_reg_wdata;
                end
                link_bringup_pkg::ADDR_GROUP_DELAY_SETTING: begin
                    group_delay_setting <= i_reg_wdata;
                end
                link_bringup_pkg::ADDR_IRQ_ENABLE_PLL_CAL: irq_enable_pll_cal <= i_reg_wdata;
                link_bringup_pkg::ADDR_IRQ_ENABLE_PRBS: irq_enable_prbs <= i_reg_wdata;
                link_bringup_pkg::ADDR_IRQ_ENABLE_PATH0_SYNC: begin
                    irq_enable_path0_sync <= i_reg_wdata;
                end
                link_bringup_pkg::ADDR_LINK_CONTROL: link_control <= i_reg_wdata;
                link_bringup_pkg::ADDR_SUBCLASS_SELECT: subclass_select <= i_reg_wdata;
                link_bringup_pkg::ADDR_MF_DELAY_0: mf_delay[0] <= i_reg_wdata;
                link_bringup_pkg::ADDR_MF_DELAY_1: mf_delay[1] <= i_reg_wdata;
                link_bringup_pkg::ADDR_MF_BUF_DELAY_0: mf_buf_delay[0] <= i_reg_wdata;
                link_bringup_pkg::ADDR_MF_BUF_DELAY_1: mf_buf_delay[1] <= i_reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Reference input synchroniser and rising edge
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sysref_sync <= 3'b000;
        end else begin
            sysref_sync <= {sysref_sync[1:0], i_sysref};
        end
    end

    assign sysref_edge = sysref_sync[1] && !sysref_sync[2];

    // ==========================================================
    // Sync control register; arm self-clears after the one-shot event
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sync_control <= link_bringup_pkg::RST_SYNC_CONTROL;
        end else if (i_reg_write && i_reg_addr == link_bringup_pkg::ADDR_SYNC_CONTROL) begin
            // Clear bits act on write and are not stored
            sync_control <= i_reg_wdata & 8'hCF;
        end else if (sync_state == link_bringup_pkg::SYNC_ARMED && sysref_edge) begin
            sync_control[link_bringup_pkg::SYNC_ARM_BIT] <= 1'b0;
        end
    end

    // ==========================================================
    // One-shot sync machine
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sync_state <= link_bringup_pkg::SYNC_IDLE;
        end else if (!sync_control[link_bringup_pkg::SYNC_ENABLE_BIT]) begin
            sync_state <= link_bringup_pkg::SYNC_IDLE;
        end else begin
            unique case (sync_state)
                link_bringup_pkg::SYNC_IDLE: begin
                    if (sync_control[link_bringup_pkg::SYNC_ARM_BIT]) begin
                        sync_state <= link_bringup_pkg::SYNC_ARMED;
                    end
                end
                link_bringup_pkg::SYNC_ARMED: begin
                    if (sysref_edge) begin
                        sync_state <= link_bringup_pkg::SYNC_DONE;
                    end
                end
                link_bringup_pkg::SYNC_DONE: begin
                    // One-shot: further edges ignored until rearmed
                    if (sync_control[link_bringup_pkg::SYNC_ARM_BIT]) begin
                        sync_state <= link_bringup_pkg::SYNC_ARMED;
                    end
                end
            endcase
        end
    end

    // Sync status flags: sticky lock and rotate, cleared by write bits
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sync_sticky <= 1'b0;
            sync_rotate <= 1'b0;
        end else if (sync_state == link_bringup_pkg::SYNC_ARMED && sysref_edge) begin
            sync_sticky <= 1'b1; // Set wins over clear
            sync_rotate <= 1'b1;
        end else if (i_reg_write && i_reg_addr == link_bringup_pkg::ADDR_SYNC_CONTROL) begin
            if (i_reg_wdata[link_bringup_pkg::SYNC_CLR_STICKY_BIT]) begin
                sync_sticky <= 1'b0;
            end
            if (i_reg_wdata[link_bringup_pkg::SYNC_CLR_LAST_BIT]) begin
                sync_rotate <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Lane input synchronisers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            lane_valid_q1 <= '0;
            lane_valid_q2 <= '0;
            lane_data_q1 <= '0;
            lane_data_q2 <= '0;
            fa_q1 <= '0;
            fa_q2 <= '0;
            ck_q1 <= '0;
            ck_q2 <= '0;
            il_q1 <= '0;
            il_q2 <= '0;
        end else begin
            lane_valid_q1 <= i_serial_lane_valid;
            lane_valid_q2 <= lane_valid_q1;
            lane_data_q1 <= i_serial_lane_inputs;
            lane_data_q2 <= lane_data_q1;
            fa_q1 <= i_lane_frame_aligned;
            fa_q2 <= fa_q1;
            ck_q1 <= i_lane_checksum_ok;
            ck_q2 <= ck_q1;
            il_q1 <= i_lane_ilas_done;
            il_q2 <= il_q1;
        end
    end

    // Per-lane monitors, active while link 0 is enabled
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        lane_monitor u_lane (
            .i_mclk(i_mclk),
            .i_rst_n(i_rst_n),
            .i_enable(o_link0_enable),
            .i_group_valid(lane_valid_q2[g]),
            .i_group(lane_data_q2[g*10 +: 10]),
            .i_frame_aligned(fa_q2[g]),
            .i_checksum_ok(ck_q2[g]),
            .i_ilas_done(il_q2[g]),
            .o_code_group_sync(cgs_lane[g]),
            .o_frame_sync(fs_lane[g]),
            .o_checksum_good(cks_lane[g]),
            .o_lane_aligned(ila_lane[g])
        );
    end

    // ==========================================================
    // Link outputs
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_link0_enable <= 1'b0;
            o_link0_sync_request_out <= 1'b0;
            o_sync_done <= 1'b0;
            o_power_down_control <= link_bringup_pkg::RST_POWER_DOWN_CONTROL;
            o_transmit_enable_mask <= link_bringup_pkg::RST_TRANSMIT_ENABLE_MASK;
        end else begin
            // Link 0 runs only when the link 0 page is selected
            o_link0_enable <= link_control[link_bringup_pkg::LINK0_ENABLE_BIT] &&
                              !link_control[link_bringup_pkg::LINK_PAGE_BIT];
            o_link0_sync_request_out <= &cgs_lane;
            o_sync_done <= (sync_state == link_bringup_pkg::SYNC_DONE);
            o_power_down_control <= power_down_control;
            o_transmit_enable_mask <= transmit_enable_mask;
        end
    end

    // ==========================================================
    // Read data, registered
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_read) begin
            unique case (i_reg_addr)
                link_bringup_pkg::ADDR_SERIAL_INTERFACE_CONFIG: begin
                    o_reg_rdata <= serial_interface_config;
                end
                link_bringup_pkg::ADDR_CHIP_KIND_CODE: o_reg_rdata <= link_bringup_pkg::ID_CHIP_KIND;
                link_bringup_pkg::ADDR_PRODUCT_CODE_LOW: begin
                    o_reg_rdata <= link_bringup_pkg::ID_PRODUCT_LOW;
                end
                link_bringup_pkg::ADDR_PRODUCT_CODE_HIGH: begin
                    o_reg_rdata <= link_bringup_pkg::ID_PRODUCT_HIGH;
                end
                link_bringup_pkg::ADDR_GRADE_AND_REVISION: begin
                    o_reg_rdata <= link_bringup_pkg::ID_GRADE_REV;
                end
                link_bringup_pkg::ADDR_CONVERTER_PAGE_SELECT: o_reg_rdata <= converter_page_select;
                link_bringup_pkg::ADDR_SCRATCH_REGISTER: o_reg_rdata <= scratch_register;
                link_bringup_pkg::ADDR_POWER_DOWN_CONTROL: o_reg_rdata <= power_down_control;
                link_bringup_pkg::ADDR_TRANSMIT_ENABLE_MASK: o_reg_rdata <= transmit_enable_mask;
                link_bringup_pkg::ADDR_OUTPUT_PROTECT_CONTROL: begin
                    o_reg_rdata <= output_protect_control;
                end
                link_bringup_pkg::ADDR_GROUP_DELAY_SETTING: o_reg_rdata <= group_delay_setting;
                link_bringup_pkg::ADDR_IRQ_ENABLE_PLL_CAL: o_reg_rdata <= irq_enable_pll_cal;
                link_bringup_pkg::ADDR_IRQ_ENABLE_PRBS: o_reg_rdata <= irq_enable_prbs;
                link_bringup_pkg::ADDR_IRQ_ENABLE_PATH0_SYNC: begin
                    o_reg_rdata <= irq_enable_path0_sync;
                end
                link_bringup_pkg::ADDR_SYNC_CONTROL: o_reg_rdata <= sync_control;
                link_bringup_pkg::ADDR_SYNC_STATUS: begin
                    o_reg_rdata <= {(sync_state == link_bringup_pkg::SYNC_ARMED), 3'b000,
                                    sync_sticky, sync_rotate, 2'b00};
                end
                link_bringup_pkg::ADDR_LINK_CONTROL: o_reg_rdata <= link_control;
                link_bringup_pkg::ADDR_SUBCLASS_SELECT: o_reg_rdata <= subclass_select;
                link_bringup_pkg::ADDR_MF_DELAY_0: o_reg_rdata <= mf_delay[0];
                link_bringup_pkg::ADDR_MF_DELAY_1: o_reg_rdata <= mf_delay[1];
                link_bringup_pkg::ADDR_MF_BUF_DELAY_0: o_reg_rdata <= mf_buf_delay[0];
                link_bringup_pkg::ADDR_MF_BUF_DELAY_1: o_reg_rdata <= mf_buf_delay[1];
                link_bringup_pkg::ADDR_CODE_GROUP_SYNC: o_reg_rdata <= all_lanes(cgs_lane);
                link_bringup_pkg::ADDR_FRAME_SYNC: o_reg_rdata <= all_lanes(fs_lane);
                link_bringup_pkg::ADDR_CHECKSUM_GOOD: o_reg_rdata <= all_lanes(cks_lane);
                link_bringup_pkg::ADDR_LANE_ALIGN: o_reg_rdata <= all_lanes(ila_lane);
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// *** link_bringup_config_regs_assertions.sv ***
// ==========================================
// Port-level checks for the register block
module link_bringup_config_regs_checker #(parameter int LANES = 4) (
    input wire logic i_mclk, i_rst_n, i_reg_write, i_reg_read, i_sysref,
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata, o_reg_rdata,
    input wire logic [7:0] o_power_down_control, o_transmit_enable_mask,
    input wire logic o_link0_sync_request_out, o_link0_enable, o_sync_done
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // Decoded writes and reads
    wire logic wlink = i_reg_write && i_reg_addr == link_bringup_pkg::ADDR_LINK_CONTROL;
    wire logic wpd = i_reg_write && i_reg_addr == link_bringup_pkg::ADDR_POWER_DOWN_CONTROL;
    wire logic wmask = i_reg_write && i_reg_addr == link_bringup_pkg::ADDR_TRANSMIT_ENABLE_MASK;
    wire logic rid = i_reg_read && i_reg_addr == link_bringup_pkg::ADDR_CHIP_KIND_CODE;
    a_link_on: assert property (wlink && i_reg_wdata == 8'h01 |=> ##1 o_link0_enable)
        else $error("link enable missing");
    a_page_off: assert property (wlink && i_reg_wdata[2] |=> ##1 !o_link0_enable)
        else $error("link enabled with page bit set");
    a_done_cause: assert property ($rose(o_sync_done) |-> $past(i_sysref, 2) ||
        $past(i_sysref, 3) || $past(i_sysref, 4) || $past(i_sysref, 5)) else $error("done without ref");
    a_req_needs_link: assert property (o_link0_sync_request_out |->
        o_link0_enable || $past(o_link0_enable, 3)) else $error("sync request without link");
    a_rdata_hold: assert property (!$past(i_reg_read) |-> $stable(o_reg_rdata))
        else $error("read data moved");
    a_id_read: assert property (rid |=> o_reg_rdata == link_bringup_pkg::ID_CHIP_KIND)
        else $error("identity read wrong");
    a_unmapped_zero: assert property (i_reg_read && i_reg_addr == 12'h0FF |=>
        o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_pd_copy: assert property (wpd |=> ##1 o_power_down_control == $past(i_reg_wdata, 2))
        else $error("power down copy wrong");
    a_mask_copy: assert property (wmask |=> ##1 o_transmit_enable_mask == $past(i_reg_wdata, 2))
        else $error("mask copy wrong");
    c_done: cover property ($rose(o_sync_done));
    c_req: cover property ($rose(o_link0_sync_request_out));
    c_link: cover property ($fell(o_link0_enable));
endmodule

// *** link_tx_model.sv ***
// ==========================================
// Transmitter model: commas, then alignment data
module link_tx_model (
    input wire logic i_mclk, i_send, i_bad_lane, i_sync_request,
    output logic [3:0] o_valid, o_frame, o_csum, o_ilas,
    output logic [39:0] o_lanes
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd = 1'b0;
    logic [9:0] grp;
    // Lane drive just after each edge
    always @(posedge i_mclk) begin
        #1;
        rd = !rd;
        grp = rd ? link_bringup_pkg::K28_5_RD_POS : link_bringup_pkg::K28_5_RD_NEG;
        {o_frame, o_csum, o_ilas} = 12'h000;
        if (i_send && !i_sync_request) begin
            o_valid = 4'hF;
            o_lanes = {4{grp}};
            if (i_bad_lane) o_lanes[39:30] = grp ^ 10'h001; // Lane 3 never completes a run
        end else if (i_send) begin
            o_valid = 4'hF;
            o_lanes = {4{10'h2AA ^ {10{rd}}}};
            {o_frame, o_csum, o_ilas} = 12'hFFF;
        end else begin
            o_valid = 4'h0;
            o_lanes = {40{rd}}; // Idle lines toggle
        end
    end
endmodule

// *** link_bringup_config_regs_tb.sv ***
module link_bringup_config_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, sysref = 0, send = 0, bad = 0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00, rdata, pd, mask;
    logic req, en, done;
    logic [3:0] val, frm, cs, il;
    logic [39:0] lanes;
    int error_cnt = 0, cmp_count = 0, n;
    logic [11:0] ra [14] = '{12'h000, 12'h003, 12'h004, 12'h005, 12'h006, 12'h008, 12'h00A,
        12'h011, 12'h012, 12'h013, 12'h014, 12'h01F, 12'h020, 12'h021};
    logic [7:0] rv [14] = '{8'h00, link_bringup_pkg::ID_CHIP_KIND, link_bringup_pkg::ID_PRODUCT_LOW,
        link_bringup_pkg::ID_PRODUCT_HIGH, link_bringup_pkg::ID_GRADE_REV, 8'h03, 8'h00, 8'h7C,
        8'h00, 8'h20, 8'h88, 8'h00, 8'h00, 8'h00};
    // ==========================================
    // Block, partner and clock
    link_bringup_config_regs link_bringup_config_regs_i (.i_mclk(clk), .i_rst_n(rst_n),
        .i_reg_write(wr_s), .i_reg_read(rd_s), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_sysref(sysref), .i_serial_lane_valid(val),
        .i_serial_lane_inputs(lanes), .i_lane_frame_aligned(frm), .i_lane_checksum_ok(cs),
        .i_lane_ilas_done(il), .o_link0_sync_request_out(req), .o_link0_enable(en),
        .o_sync_done(done), .o_power_down_control(pd), .o_transmit_enable_mask(mask));
    link_tx_model link_tx_model_i (.i_mclk(clk), .i_send(send), .i_bad_lane(bad),
        .i_sync_request(req), .o_valid(val), .o_frame(frm), .o_csum(cs), .o_ilas(il),
        .o_lanes(lanes));
    initial forever #5 clk = !clk;
    // Shared bus cycles and compare
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk) #1 {wr_s, addr, wdata} = {1'b1, a, d};
        @(posedge clk) #1 wr_s = 0;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk) #1 {rd_s, addr} = {1'b1, a};
        @(posedge clk) #1 rd_s = 0;
        chk(rdata, e);
    endtask
    task pulse_ref();
        @(posedge clk) #1 sysref = 1;
        repeat (4) @(posedge clk);
        #1 sysref = 0;
        repeat (8) @(posedge clk);
    endtask
    task test_done();
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task t_regs();
        for (int i = 0; i < 14; i++) rd(ra[i], rv[i]);
        wr(12'h003, 8'h00);
        rd(12'h003, link_bringup_pkg::ID_CHIP_KIND);
        wr(12'h00A, 8'hA5);
        rd(12'h00A, 8'hA5);
        wr(12'h011, 8'h3C);
        wr(12'h012, 8'h03);
        @(posedge clk) #1;
        chk(pd, 8'h3C);
        chk(mask, 8'h03);
        rd(12'h0FF, 8'h00);
    endtask
    task t_sync();
        for (int i = 0; i < 4; i++) wr(12'h304 + 12'(i), i < 2 ? 8'h00 : 8'h0A);
        rd(12'h306, 8'h0A);
        wr(12'h03A, 8'h01);
        rd(12'h03A, 8'h01);
        wr(12'h03A, 8'h81);
        pulse_ref();
        chk({7'h00, done}, 8'h00);
        wr(12'h03A, 8'hC1);
        rd(12'h03B, 8'h80);
        pulse_ref();
        for (n = 0; n < 20 && done !== 1'b1; n++) @(posedge clk);
        chk({7'h00, done}, 8'h01);
        rd(12'h03A, 8'h81);
        rd(12'h03B, 8'h0C);
        wr(12'h03A, 8'hA1);
        rd(12'h03A, 8'h81);
        pulse_ref();
        rd(12'h03B, 8'h04);
    endtask
    task t_link();
        {send, bad} = 2'b11;
        wr(12'h300, 8'h01);
        @(posedge clk) #1;
        chk({7'h00, en}, 8'h01);
        repeat (30) @(posedge clk);
        chk({7'h00, req}, 8'h00);
        rd(12'h470, 8'h00);
        #1 bad = 0;
        for (n = 0; n < 30 && req !== 1'b1; n++) @(posedge clk);
        chk({7'h00, req}, 8'h01);
        repeat (10) @(posedge clk);
        for (int i = 0; i < 4; i++) rd(12'h470 + 12'(i), 8'hFF);
        wr(12'h300, 8'h05);
        repeat (6) @(posedge clk);
        chk({6'h00, en, req}, 8'h00);
        rd(12'h470, 8'h00);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1;
        t_regs();
        t_sync();
        t_link();
        test_done();
    end
    initial begin
        #100us;
        error_cnt++;
        test_done();
    end
endmodule
bind link_bringup_config_regs link_bringup_config_regs_checker #(.LANES(LANES)) chk_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
    .i_sysref(i_sysref), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_power_down_control(o_power_down_control),
    .o_transmit_enable_mask(o_transmit_enable_mask), .o_link0_enable(o_link0_enable),
    .o_link0_sync_request_out(o_link0_sync_request_out), .o_sync_done(o_sync_done));
